/* File: cold_load_pkg.sv */
`default_nettype none
package cold_load_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] LOADOFF_OFS  = 8'h04;
    localparam logic [7:0] SETTLE_OFS   = 8'h08;
    localparam logic [7:0] MAXBLK_OFS   = 8'h0C;
    localparam logic [7:0] THR_OFS      = 8'h10;
    localparam logic [7:0] STATUS_OFS   = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;

    // control field positions
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_MODE_LSB    = 1;
    localparam int CTRL_EXT_BLK_BIT = 3;
    localparam int CTRL_SW_BLK_BIT  = 4;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_001F;

    // status field positions
    localparam int ST_ACTIVE_BIT  = 0;
    localparam int ST_NOLOAD_BIT  = 1;
    localparam int ST_INRUSH_BIT  = 2;
    localparam int ST_BLOCKED_BIT = 3;
    localparam int ST_STATE_LSB   = 4;
    localparam int ST_PINS_LSB    = 8;

    // interrupt event bits
    localparam int IRQ_W          = 4;
    localparam int IRQ_RISE_BIT   = 0;
    localparam int IRQ_FALL_BIT   = 1;
    localparam int IRQ_INRUSH_BIT = 2;
    localparam int IRQ_MAXEXP_BIT = 3;

    // reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
    localparam logic [31:0] LOADOFF_RST = 32'h0000_0064;
    localparam logic [31:0] SETTLE_RST  = 32'h0000_0064;
    localparam logic [31:0] MAXBLK_RST  = 32'h0000_03E8;
    localparam logic [31:0] THR_RST     = 32'h0000_0100;
    localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

    // synchronised pin indices
    localparam int PIN_N   = 4;
    localparam int PIN_BKR = 0;
    localparam int PIN_UC  = 1;
    localparam int PIN_EXT = 2;
    localparam int PIN_AR  = 3;

    typedef enum logic [1:0] {
        MODE_BKR   = 2'b00,
        MODE_UNDER = 2'b01,
        MODE_AND   = 2'b10,
        MODE_OR    = 2'b11
    } mode_e;

    typedef enum logic [2:0] {
        ST_WARM    = 3'b000,
        ST_LOADOFF = 3'b001,
        ST_COLD    = 3'b010,
        ST_INRUSH  = 3'b011,
        ST_SETTLE  = 3'b100
    } state_e;

endpackage
`default_nettype wire

/* File: cold_load_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module cold_load_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] preset,
    output logic                  expired
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } timer_s;

    timer_s cur;
    timer_s nxt;

    // count while running, saturate at preset, clear when run drops
    always_comb begin
        nxt = cur;
        if (!run) begin
            nxt.cnt = '0;
        end else if (cur.cnt < preset) begin
            nxt.cnt = cur.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // compare with >= so a lowered preset still ends the wait
    assign expired = run && (cur.cnt >= preset);

endmodule
`default_nettype wire

/* File: cold_load_supervisor.sv */
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cold_load_supervisor #(
    parameter int CUR_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [7:0]       addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr_stb,
    input  wire logic             rd_stb,
    output logic      [31:0]      rdata,
    input  wire logic             breaker_position_criterion,
    input  wire logic             undercurrent_in,
    input  wire logic             ext_block,
    input  wire logic             auto_reclose_sequence,
    input  wire logic [CUR_W-1:0] load_current,
    output logic                  cold_load_active,
    output logic                  no_load_current_flag,
    output logic                  irq
);

    typedef struct packed {
        logic [cold_load_pkg::PIN_N-1:0] s1;
        logic [cold_load_pkg::PIN_N-1:0] s2;
        logic [cold_load_pkg::PIN_N-1:0] s3;
        logic [cold_load_pkg::PIN_N-1:0] filt;
        cold_load_pkg::state_e           st;
        logic                            seen;
        logic                            active;
        logic [31:0]                     ctrl;
        logic [31:0]                     loadoff;
        logic [31:0]                     settle;
        logic [31:0]                     maxblk;
        logic [CUR_W-1:0]                thr;
        logic [cold_load_pkg::IRQ_W-1:0] irq_stat;
        logic [cold_load_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0]                     rdata;
    } core_s;

    core_s cur;
    core_s nxt;

    logic [1:0] rst_sync_r;
    logic       rst_n;
    logic       lo_exp;
    logic       st_exp;
    logic       mx_exp;
    logic       lo_run;
    logic       st_run;
    logic       mx_run;
    logic       blocked;
    logic       cold;
    logic       above;
    logic       below90;
    logic [cold_load_pkg::IRQ_W-1:0] ev;

    // cold criterion per selected mode, used by logic and checks
    function automatic logic cold_crit(input logic [1:0] mode, input logic bkr_open, input logic uc);
        case (mode)
            cold_load_pkg::MODE_BKR:   cold_crit = bkr_open;
            cold_load_pkg::MODE_UNDER: cold_crit = uc;
            cold_load_pkg::MODE_AND:   cold_crit = bkr_open & uc;
            cold_load_pkg::MODE_OR:    cold_crit = bkr_open | uc;
            default:                   cold_crit = 1'b0;
        endcase
    endfunction

    // 10*cur <= 9*thr, done with shifts to keep widths exact
    function automatic logic at_or_below90(input logic [CUR_W-1:0] c, input logic [CUR_W-1:0] t);
        logic [CUR_W+3:0] c10;
        logic [CUR_W+3:0] t9;
        c10 = ({4'h0, c} << 3) + ({4'h0, c} << 1);
        t9  = ({4'h0, t} << 3) + {4'h0, t};
        at_or_below90 = (c10 <= t9);
    endfunction

    function automatic logic is_active_state(input cold_load_pkg::state_e s);
        is_active_state = (s == cold_load_pkg::ST_COLD) || (s == cold_load_pkg::ST_INRUSH) ||
                          (s == cold_load_pkg::ST_SETTLE);
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // derived conditions from registered state and the load_current input
    always_comb begin
        blocked = ~cur.ctrl[cold_load_pkg::CTRL_EN_BIT] | cur.ctrl[cold_load_pkg::CTRL_SW_BLK_BIT]
                | (cur.ctrl[cold_load_pkg::CTRL_EXT_BLK_BIT] & cur.filt[cold_load_pkg::PIN_EXT])
                | cur.filt[cold_load_pkg::PIN_AR];
        cold    = cold_crit(cur.ctrl[cold_load_pkg::CTRL_MODE_LSB +: 2],
                            cur.filt[cold_load_pkg::PIN_BKR], cur.filt[cold_load_pkg::PIN_UC]);
        above   = load_current > cur.thr;
        below90 = at_or_below90(load_current, cur.thr);
        lo_run  = (cur.st == cold_load_pkg::ST_LOADOFF);
        st_run  = (cur.st == cold_load_pkg::ST_SETTLE);
        mx_run  = (cur.st == cold_load_pkg::ST_INRUSH) || (cur.st == cold_load_pkg::ST_SETTLE);
    end

    cold_load_timer #(.CNT_W(32)) u_loadoff (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .run     (lo_run),
        .preset  (cur.loadoff),
        .expired (lo_exp)
    );

    cold_load_timer #(.CNT_W(32)) u_settle (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .run     (st_run),
        .preset  (cur.settle),
        .expired (st_exp)
    );

    cold_load_timer #(.CNT_W(32)) u_maxblk (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .run     (mx_run),
        .preset  (cur.maxblk),
        .expired (mx_exp)
    );

    // next state: pins, supervisor sequence, registers, read data
    always_comb begin
        nxt = cur;
        ev  = '0;
        // three-stage sync; a change counts once stages two and three agree
        nxt.s1   = {auto_reclose_sequence, ext_block, undercurrent_in, breaker_position_criterion};
        nxt.s2   = cur.s1;
        nxt.s3   = cur.s2;
        nxt.filt = (cur.s2 & cur.s3) | (cur.filt & (cur.s2 ^ cur.s3));

        case (cur.st)
            cold_load_pkg::ST_WARM: begin
                if (cold) begin
                    nxt.st = cold_load_pkg::ST_LOADOFF;
                end
            end
            cold_load_pkg::ST_LOADOFF: begin
                if (!cold) begin
                    nxt.st = cold_load_pkg::ST_WARM;
                end else if (lo_exp) begin
                    nxt.st = cold_load_pkg::ST_COLD;
                end
            end
            cold_load_pkg::ST_COLD: begin
                if (!cold) begin
                    nxt.st   = cold_load_pkg::ST_INRUSH;
                    nxt.seen = 1'b0;
                end
            end
            cold_load_pkg::ST_INRUSH: begin
                if (mx_exp) begin
                    nxt.st = cold_load_pkg::ST_WARM;
                    ev[cold_load_pkg::IRQ_MAXEXP_BIT] = 1'b1;
                end else if (cur.seen && below90) begin
                    nxt.st = cold_load_pkg::ST_SETTLE;
                end
            end
            cold_load_pkg::ST_SETTLE: begin
                if (st_exp) begin
                    nxt.st = cold_load_pkg::ST_WARM;
                end else if (mx_exp) begin
                    nxt.st = cold_load_pkg::ST_WARM;
                    ev[cold_load_pkg::IRQ_MAXEXP_BIT] = 1'b1;
                end else if (!below90) begin
                    nxt.st = cold_load_pkg::ST_INRUSH;
                end
            end
            default: begin
                nxt.st = cold_load_pkg::ST_WARM;
            end
        endcase

        // latch that inrush has been seen during supervision
        if (mx_run && above && !cur.seen) begin
            nxt.seen = 1'b1;
            ev[cold_load_pkg::IRQ_INRUSH_BIT] = 1'b1;
        end

        // blocking overrides everything except the inrush event and drops all timers via state
        if (blocked) begin
            nxt.st   = cold_load_pkg::ST_WARM;
            nxt.seen = 1'b0;
            ev[cold_load_pkg::IRQ_MAXEXP_BIT] = 1'b0;
        end

        // output is a status level only, never a trip
        nxt.active = is_active_state(nxt.st);
        ev[cold_load_pkg::IRQ_RISE_BIT] = nxt.active & ~cur.active;
        ev[cold_load_pkg::IRQ_FALL_BIT] = ~nxt.active & cur.active;

        // register writes
        if (wr_stb) begin
            case (addr)
                cold_load_pkg::CTRL_OFS:     nxt.ctrl    = wdata & cold_load_pkg::CTRL_WMASK;
                cold_load_pkg::LOADOFF_OFS:  nxt.loadoff = wdata;
                cold_load_pkg::SETTLE_OFS:   nxt.settle  = wdata;
                cold_load_pkg::MAXBLK_OFS:   nxt.maxblk  = wdata;
                cold_load_pkg::THR_OFS:      nxt.thr     = wdata[CUR_W-1:0];
                cold_load_pkg::IRQ_STAT_OFS: nxt.irq_stat = cur.irq_stat & ~wdata[cold_load_pkg::IRQ_W-1:0];
                cold_load_pkg::IRQ_MASK_OFS: nxt.irq_mask = wdata[cold_load_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        nxt.irq_stat = nxt.irq_stat | ev;

        // read data valid only in the cycle after the strobe
        nxt.rdata = 32'h0000_0000;
        if (rd_stb) begin
            case (addr)
                cold_load_pkg::CTRL_OFS:     nxt.rdata = cur.ctrl;
                cold_load_pkg::LOADOFF_OFS:  nxt.rdata = cur.loadoff;
                cold_load_pkg::SETTLE_OFS:   nxt.rdata = cur.settle;
                cold_load_pkg::MAXBLK_OFS:   nxt.rdata = cur.maxblk;
                cold_load_pkg::THR_OFS:      nxt.rdata[CUR_W-1:0] = cur.thr;
                cold_load_pkg::STATUS_OFS: begin
                    nxt.rdata[cold_load_pkg::ST_ACTIVE_BIT]  = cur.active;
                    nxt.rdata[cold_load_pkg::ST_NOLOAD_BIT]  = cur.filt[cold_load_pkg::PIN_UC];
                    nxt.rdata[cold_load_pkg::ST_INRUSH_BIT]  = cur.seen;
                    nxt.rdata[cold_load_pkg::ST_BLOCKED_BIT] = blocked;
                    nxt.rdata[cold_load_pkg::ST_STATE_LSB +: 3] = cur.st;
                    nxt.rdata[cold_load_pkg::ST_PINS_LSB +: cold_load_pkg::PIN_N] = cur.filt;
                end
                cold_load_pkg::IRQ_STAT_OFS: nxt.rdata[cold_load_pkg::IRQ_W-1:0] = cur.irq_stat;
                cold_load_pkg::IRQ_MASK_OFS: nxt.rdata[cold_load_pkg::IRQ_W-1:0] = cur.irq_mask;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.st       <= cold_load_pkg::ST_WARM;
            cur.ctrl     <= cold_load_pkg::CTRL_RST;
            cur.loadoff  <= cold_load_pkg::LOADOFF_RST;
            cur.settle   <= cold_load_pkg::SETTLE_RST;
            cur.maxblk   <= cold_load_pkg::MAXBLK_RST;
            cur.thr      <= cold_load_pkg::THR_RST[CUR_W-1:0];
            cur.irq_mask <= cold_load_pkg::IRQ_MASK_RST;
        end else begin
            cur <= nxt;
        end
    end

    // outputs straight from flops except irq, gated from irq_stat and irq_mask
    assign rdata                = cur.rdata;
    assign cold_load_active     = cur.active;
    assign no_load_current_flag = cur.filt[cold_load_pkg::PIN_UC];
    assign irq                  = |(cur.irq_stat & cur.irq_mask);

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence cold_seen_s;
        cur.st == cold_load_pkg::ST_WARM && cold && !blocked;
    endsequence

    sequence loadoff_done_s;
        cur.st == cold_load_pkg::ST_LOADOFF && lo_exp && cold && !blocked;
    endsequence

    sequence settle_done_s;
        cur.st == cold_load_pkg::ST_SETTLE && st_exp && !blocked;
    endsequence

    property settle_release_p;
        settle_done_s |=> !cold_load_active && cur.st == cold_load_pkg::ST_WARM;
    endproperty

    loadoff_start_a: assert property (cold_seen_s |=> cur.st == cold_load_pkg::ST_LOADOFF)
        else $error("load-off delay did not start");

    active_rise_a: assert property (loadoff_done_s |=> cold_load_active ##1 (cold_load_active || $past(blocked)))
        else $error("active not raised after load-off delay");

    inrush_start_a: assert property (cur.st == cold_load_pkg::ST_COLD && !cold && !blocked
        |=> cur.st == cold_load_pkg::ST_INRUSH && !cur.seen && cold_load_active)
        else $error("inrush stage not started when cold ended");

    inrush_seen_a: assert property (mx_run && above && !blocked |=> cur.seen)
        else $error("inrush above threshold not registered");

    inrush_end_a: assert property (cur.st == cold_load_pkg::ST_INRUSH && cur.seen && below90
        && !mx_exp && !blocked |=> cur.st == cold_load_pkg::ST_SETTLE)
        else $error("inrush end at ninety percent missed");

    settle_hold_a: assert property (cur.st == cold_load_pkg::ST_SETTLE && !st_exp && !mx_exp
        && !blocked |=> cold_load_active)
        else $error("active dropped before settle expiry");

    settle_release_a: assert property (settle_release_p)
        else $error("settle expiry did not end supervision");

    max_end_a: assert property (mx_run && mx_exp && !st_exp && !blocked |=> !cold_load_active
        && cur.irq_stat[cold_load_pkg::IRQ_MAXEXP_BIT])
        else $error("max-block expiry did not drop active");

    block_clear_a: assert property (blocked |=> !cold_load_active && !lo_run && !mx_run)
        else $error("blocking did not suppress function");

    ar_block_a: assert property (cur.filt[cold_load_pkg::PIN_AR] |=> !cold_load_active [*2])
        else $error("auto-reclose did not block function");

    withdraw_clear_a: assert property (lo_run && !cold |=> !lo_run ##1 (!lo_run || $past(cold)))
        else $error("load-off timer not withdrawn");

    noload_flag_a: assert property ($rose(cur.s2[cold_load_pkg::PIN_UC] & cur.s3[cold_load_pkg::PIN_UC])
        |=> no_load_current_flag)
        else $error("undercurrent flag not shown");

endmodule
`default_nettype wire

/* File: cold_load_feeder_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cold_load_feeder_model #(
    parameter int CUR_W    = 16,
    parameter int UC_LEVEL = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             bkr_open_cmd,
    input  wire logic [CUR_W-1:0] current_cmd,
    output logic                  breaker_position_criterion,
    output logic                  undercurrent_in,
    output logic      [CUR_W-1:0] load_current
);
    // defined levels from time zero so the pin synchronisers never see unknowns
    initial begin
        breaker_position_criterion = 1'b0;
        undercurrent_in            = 1'b0;
        load_current               = '0;
    end

    // one breaker and its own transformers feed position and current together
    always @(posedge ref_clk) begin
        breaker_position_criterion <= bkr_open_cmd;
        load_current               <= current_cmd;
        undercurrent_in            <= (current_cmd < CUR_W'(UC_LEVEL)); // no hysteresis modelled
    end
endmodule
`default_nettype wire

/* File: cold_load_supervisor_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cold_load_supervisor_tb;
    localparam int          N_OFF = 8;
    localparam int          N_SET = 6;
    localparam int          N_MAX = 60;
    localparam int          LIMIT = 3000;
    localparam logic [15:0] THR   = 16'h0100;
    localparam logic [15:0] LIM   = (THR * 9) / 10;
    localparam logic [39:0] RST_TBL [8] = '{
        {cold_load_pkg::CTRL_OFS, cold_load_pkg::CTRL_RST},
        {cold_load_pkg::LOADOFF_OFS, cold_load_pkg::LOADOFF_RST},
        {cold_load_pkg::SETTLE_OFS, cold_load_pkg::SETTLE_RST},
        {cold_load_pkg::MAXBLK_OFS, cold_load_pkg::MAXBLK_RST},
        {cold_load_pkg::THR_OFS, cold_load_pkg::THR_RST},
        {cold_load_pkg::IRQ_MASK_OFS, 28'h0, cold_load_pkg::IRQ_MASK_RST},
        {cold_load_pkg::STATUS_OFS, 32'h0},
        {8'h20, 32'h0}};

    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        rd_q = 1'b0;
    logic [31:0] rdata;
    logic        bkr_open_cmd = 1'b0;
    logic [15:0] current_cmd = 16'h0032;
    logic        ext_block = 1'b0;
    logic        auto_reclose_sequence = 1'b0;
    logic        breaker_position_criterion;
    logic        undercurrent_in;
    logic [15:0] load_current;
    logic        cold_load_active;
    logic        no_load_current_flag;
    logic        irq;
    logic        b;
    logic        u;
    logic        cold;
    logic [15:0] peak;
    logic [31:0] exp_q[$];
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    cold_load_feeder_model feeder (
        .ref_clk                    (ref_clk),
        .bkr_open_cmd               (bkr_open_cmd),
        .current_cmd                (current_cmd),
        .breaker_position_criterion (breaker_position_criterion),
        .undercurrent_in            (undercurrent_in),
        .load_current               (load_current)
    );

    cold_load_supervisor dut (
        .ref_clk                    (ref_clk),
        .nrst                       (nrst),
        .addr                       (addr),
        .wdata                      (wdata),
        .wr_stb                     (wr_stb),
        .rd_stb                     (rd_stb),
        .rdata                      (rdata),
        .breaker_position_criterion (breaker_position_criterion),
        .undercurrent_in            (undercurrent_in),
        .ext_block                  (ext_block),
        .auto_reclose_sequence      (auto_reclose_sequence),
        .load_current               (load_current),
        .cold_load_active           (cold_load_active),
        .no_load_current_flag       (no_load_current_flag),
        .irq                        (irq)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe; oldest note is compared
    always @(posedge ref_clk) rd_q <= rd_stb;
    always @(negedge ref_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                check("rdata unexpected", rdata, 32'hFFFF_FFFF);
            end else begin
                check("rdata", rdata, exp_q.pop_front());
            end
        end
    end

    // hang guard, far above the length of the sequence
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask

    task automatic feed(input logic bo, input logic [15:0] c);
        @(posedge ref_clk);
        bkr_open_cmd <= bo;
        current_cmd  <= c;
    endtask

    // windows leave slack for the model register and the three-stage pin filter
    task automatic act_at(input int n, input logic e);
        repeat (n) @(negedge ref_clk);
        check("cold_load_active", {31'h0, cold_load_active}, {31'h0, e});
    endtask

    initial begin
        void'($urandom(32'h8658));
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (RST_TBL[i]) rd(RST_TBL[i][39:32], RST_TBL[i][31:0]);
        wr(cold_load_pkg::CTRL_OFS, ($urandom() & 32'hFFFF_FFE0) | 32'h1);
        rd(cold_load_pkg::CTRL_OFS, 32'h1);
        wr(cold_load_pkg::LOADOFF_OFS, 32'(N_OFF));
        wr(cold_load_pkg::SETTLE_OFS, 32'(N_SET));
        wr(cold_load_pkg::MAXBLK_OFS, 32'(N_MAX));
        wr(cold_load_pkg::THR_OFS, {16'h0, THR});
        wr(cold_load_pkg::STATUS_OFS, 32'hFFFF_FFFF);
        rd(cold_load_pkg::LOADOFF_OFS, 32'(N_OFF));
        rd(cold_load_pkg::STATUS_OFS, 32'h0);
        // every mode against breaker only, no current only, and both
        for (int m = 0; m < 4; m++) begin
            for (int k = 1; k < 4; k++) begin
                b = k[0];
                u = k[1];
                cold = (m == 0) ? b : (m == 1) ? u : (m == 2) ? (b & u) : (b | u);
                wr(cold_load_pkg::CTRL_OFS, {29'h0, m[1:0], 1'b1});
                feed(b, u ? 16'h0000 : 16'h0032);
                act_at(N_OFF - 2, 1'b0);
                act_at(10, cold);
                check("no_load_current_flag", {31'h0, no_load_current_flag}, {31'h0, u});
                wr(cold_load_pkg::CTRL_OFS, {29'h0, m[1:0], 1'b0});
                act_at(4, 1'b0);
                feed(1'b0, 16'h0032);
                repeat (6) @(posedge ref_clk);
            end
        end
        // inrush rise, hold just above ninety percent, then fall to it
        wr(cold_load_pkg::IRQ_STAT_OFS, 32'hF);
        wr(cold_load_pkg::CTRL_OFS, 32'h1);
        feed(1'b1, 16'h0000);
        act_at(N_OFF + 8, 1'b1);
        peak = THR + 16'd1 + 16'($urandom() % 400);
        feed(1'b0, peak);
        act_at(8, 1'b1);
        feed(1'b0, LIM + 16'd1);
        act_at(16, 1'b1);
        feed(1'b0, LIM);
        act_at(N_SET - 2, 1'b1);
        act_at(8, 1'b0);
        rd(cold_load_pkg::IRQ_STAT_OFS, 32'h7);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(cold_load_pkg::IRQ_STAT_OFS, 32'h7);
        rd(cold_load_pkg::IRQ_STAT_OFS, 32'h0);
        // no inrush at all: only the max-block timer ends the enable
        wr(cold_load_pkg::IRQ_MASK_OFS, 32'h8);
        feed(1'b1, 16'h0000);
        act_at(N_OFF + 8, 1'b1);
        feed(1'b0, 16'h0000);
        act_at(N_MAX - 4, 1'b1);
        check("irq early", {31'h0, irq}, 32'h0);
        act_at(12, 1'b0);
        check("irq", {31'h0, irq}, 32'h1);
        rd(cold_load_pkg::IRQ_STAT_OFS, 32'hB);
        wr(cold_load_pkg::IRQ_STAT_OFS, 32'hB);
        repeat (2) @(negedge ref_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        // external, auto-reclose and software blocking in the cold state
        feed(1'b1, 16'h0000);
        act_at(N_OFF + 8, 1'b1);
        @(posedge ref_clk);
        ext_block <= 1'b1;
        act_at(6, 1'b1);
        wr(cold_load_pkg::CTRL_OFS, 32'h9);
        act_at(3, 1'b0);
        @(posedge ref_clk);
        ext_block <= 1'b0;
        act_at(N_OFF, 1'b0);
        act_at(8, 1'b1);
        @(posedge ref_clk);
        auto_reclose_sequence <= 1'b1;
        act_at(7, 1'b0);
        @(posedge ref_clk);
        auto_reclose_sequence <= 1'b0;
        act_at(N_OFF + 8, 1'b1);
        wr(cold_load_pkg::CTRL_OFS, 32'h11);
        act_at(3, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
